// ---- common/mcc_pkg.sv ----
// Shared types and constants for the meter channel conditioning block
package mcc_pkg;
	// Data widths
	localparam int DW = 32;
	localparam int WIDE = 2 * DW;
	localparam int ACC_W = 48;
	localparam int LP_W = ACC_W + DW;
	localparam int AW = 12;
	// Channel counts
	localparam int NCH = 7;
	localparam int NCUR = 4;
	localparam int NPH = 3;
	localparam int NREG = 6;
	localparam int NTHR = 5;
	localparam int VOFF = 4;
	typedef logic signed [DW-1:0] mcc_smp_t;
	typedef logic [DW-1:0] mcc_word_t;
	typedef logic [2:0] mcc_region_t;
	// One 8 ksps sample on every channel
	typedef struct packed {
		mcc_smp_t ia;
		mcc_smp_t ib;
		mcc_smp_t ic;
		mcc_smp_t ineu;
		mcc_smp_t va;
		mcc_smp_t vb;
		mcc_smp_t vc;
	} mcc_chan_s;
	// Latest current rms per phase
	typedef struct packed {
		mcc_word_t ia;
		mcc_word_t ib;
		mcc_word_t ic;
	} mcc_rms_s;
	// Register byte offsets
	localparam logic [AW-1:0] CFG0_OFF = 12'h000;
	localparam logic [AW-1:0] CFG2_OFF = 12'h004;
	localparam logic [AW-1:0] ACCM_OFF = 12'h008;
	localparam logic [AW-1:0] DICO_OFF = 12'h00c;
	localparam logic [AW-1:0] IGAIN_OFF = 12'h010;
	localparam logic [AW-1:0] REGION_OFF = 12'h020;
	localparam logic [AW-1:0] THR_LO_OFF = 12'h040;
	localparam logic [AW-1:0] THR_HI_OFF = 12'h060;
	localparam logic [AW-1:0] MTGAIN_OFF = 12'h100;
	localparam logic [AW-1:0] PHCAL_OFF = 12'h200;
	localparam int REG_STRIDE = 4;
	localparam int PH_STRIDE = 32;
	// Field positions
	localparam int CFG0_HPFDIS = 0;
	localparam int CFG0_PHINT = 1;
	localparam int CFG0_NINT = 2;
	localparam int CFG0_MULTIPOINT_ENABLE = 3;
	localparam int ACCM_DERIVE = 0;
	localparam int CFG2_CORNER_LSB = 0;
	localparam int CORNER_W = 3;
	localparam int REGION_W = 4;
	// Writable bits and reset values
	localparam mcc_word_t CFG0_MASK = 32'h0000000f;
	localparam mcc_word_t CFG2_MASK = 32'h00000007;
	localparam mcc_word_t ACCM_MASK = 32'h00000001;
	localparam mcc_word_t CFG2_RST = 32'h00000006;
	localparam mcc_word_t DICO_RST = 32'hffffe000;
	// Arithmetic scaling
	localparam int HPF_SHIFT_BASE = 4;
	localparam int GAIN_FRAC = 27;
	localparam int INT_COEF_FRAC = 31;
	localparam int INT_OUT_SHIFT = 4;
	// Multipoint region stepping limits
	localparam mcc_region_t REGION_UP_MAX = 3'h3;
	localparam mcc_region_t REGION_DN_MIN = 3'h1;

	// Byte-lane merge for a Wishbone write
	function automatic mcc_word_t mcc_merge(mcc_word_t old, mcc_word_t nw, logic [3:0] sel);
		for (int b = 0; b < DW / 8; b++) begin
			mcc_merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
		end
	endfunction : mcc_merge
endpackage : mcc_pkg

// ---- rtl/mcc_gain_phase.sv ----
// Current gain, multipoint gain and phase compensation filter, one channel
`timescale 1ns/1ps
module mcc_gain_phase import mcc_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Sample in
	input wire logic in_valid,
	input wire mcc_smp_t x,
	// Coefficients
	input wire mcc_smp_t igain,
	input wire logic mt_en,
	input wire mcc_smp_t mtgain,
	input wire mcc_smp_t phcal,
	// Sample out
	output mcc_smp_t y
);
	logic signed [WIDE-1:0] p1; // Main gain product
	logic signed [WIDE-1:0] p2; // Multipoint gain product
	logic signed [WIDE-1:0] p3; // Phase filter product
	mcc_smp_t g1;
	mcc_smp_t g2;
	mcc_smp_t y_next;
	mcc_smp_t xd_reg; // Gained sample, one back
	mcc_smp_t y_reg; // Filter output, one back

	// Gain chain then first-order all-pass; zero coefficient is a pure delay
	always_comb begin
		p1 = WIDE'(x) * WIDE'(igain);
		g1 = x + DW'(p1 >>> GAIN_FRAC);
		p2 = WIDE'(g1) * WIDE'(mtgain);
		g2 = mt_en ? g1 + DW'(p2 >>> GAIN_FRAC) : g1;
		p3 = WIDE'(phcal) * (WIDE'(g2) - WIDE'(y_reg));
		// Positive coefficient shortens the delay, correcting a lagging current
		y_next = xd_reg + DW'(p3 >>> GAIN_FRAC);
	end

	// Filter state
	always_ff @(posedge mclk) begin
		if (rst) begin
			xd_reg <= '0;
			y_reg <= '0;
		end else if (in_valid) begin
			xd_reg <= g2;
			y_reg <= y_next;
		end
	end

	assign y = y_reg;
endmodule : mcc_gain_phase

// ---- rtl/mcc_hpf_int.sv ----
// High-pass dc removal followed by the optional integrator, one channel
`timescale 1ns/1ps
module mcc_hpf_int import mcc_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Sample in
	input wire logic in_valid,
	input wire mcc_smp_t x,
	// Controls
	input wire logic hpf_dis,
	input wire logic [CORNER_W-1:0] corner,
	input wire logic int_en,
	input wire mcc_smp_t dico,
	// Sample out
	output mcc_smp_t y
);
	logic signed [WIDE-1:0] d; // Unscaled difference term
	logic signed [WIDE-1:0] h; // Filter output, wide
	logic signed [ACC_W-1:0] acc_reg; // Integrator state
	logic signed [ACC_W-1:0] acc_next;
	logic signed [LP_W-1:0] lp; // Leak product
	mcc_smp_t xp_reg; // Previous input
	mcc_smp_t hp_reg; // Previous filter output
	mcc_smp_t hsel; // Filtered or bypassed value
	mcc_smp_t y_reg;
	logic [3:0] sh; // Pole shift, one more per halving of the corner

	// One-pole high-pass and leaky integrator
	always_comb begin
		sh = 4'(HPF_SHIFT_BASE) + 4'(corner);
		d = WIDE'(hp_reg) + WIDE'(x) - WIDE'(xp_reg);
		h = d - (d >>> sh);
		hsel = hpf_dis ? x : DW'(h);
		lp = LP_W'(acc_reg) * LP_W'(dico);
		acc_next = acc_reg + ACC_W'(hsel) + ACC_W'(lp >>> INT_COEF_FRAC);
	end

	// State advances only on a processing sample
	always_ff @(posedge mclk) begin
		if (rst) begin
			xp_reg <= '0;
			hp_reg <= '0;
			acc_reg <= '0;
			y_reg <= '0;
		end else if (in_valid) begin
			xp_reg <= x;
			// Filter keeps running while bypassed so re-enabling is smooth
			hp_reg <= DW'(h);
			acc_reg <= int_en ? acc_next : '0;
			y_reg <= int_en ? DW'(acc_next >>> INT_OUT_SHIFT) : hsel;
		end
	end

	assign y = y_reg;
endmodule : mcc_hpf_int

// ---- rtl/mcc_top.sv ----
// Meter channel conditioning datapath with its Wishbone register file
// Summary of operation
// - Derive phase B current as minus A minus C
// - High-pass on by default, bypass bit disables
// - Three-bit corner select, reset code six
// - Each corner code gives tabulated gain, settling
// - Phase integrator bit enables A, B, C integrators
// - Neutral integrator bit, independent of phase bit
// - Integrator slopes minus twenty dB per decade
// - Phase adjustment resolution one millidegree
// - Voltage channels delayed exactly one sample
// - Current all-pass coefficient is phase cal scaled
// - Positive correction fixes lagging current
// - Correction range minus 15 to plus 2.25
// - Main current gain always applied
// - Multipoint adds one of six region gains; code never climbs past region four, so region five is unused
// - Multipoint also selects region phase coefficient
// - Gain is one plus signed cal over 2^27
// - Region steps up above high, down below low
// - Multipoint off after reset, enable bit
// - Multipoint off uses region zero, no gain
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module mcc_top import mcc_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire mcc_word_t wb_dat_i,
	output mcc_word_t wb_dat_o,
	output logic wb_ack_o,
	// Samples and rms from the decimators
	input wire logic smp_valid,
	input wire mcc_chan_s smp_in,
	input wire mcc_rms_s rms_in,
	// Conditioned samples
	output logic out_valid,
	output mcc_chan_s out_smp
);
	// Software registers
	mcc_word_t cfg0_reg; // Bypass, integrators, multipoint enable
	mcc_word_t cfg2_reg; // Corner select
	mcc_word_t accm_reg; // Phase B derivation
	mcc_word_t dico_reg; // Integrator coefficient
	mcc_smp_t igain_reg [NCUR]; // Main current gains A, B, C, N
	mcc_word_t thr_lo_reg [NTHR]; // Multipoint low thresholds
	mcc_word_t thr_hi_reg [NTHR]; // Multipoint high thresholds
	mcc_smp_t mtg_reg [NPH][NREG]; // Multipoint gains
	mcc_smp_t phc_reg [NPH][NREG]; // Phase coefficients
	// Block state
	mcc_region_t region_reg [NPH]; // Current region per phase
	logic ack_reg;
	mcc_word_t dat_reg;
	mcc_word_t rd_word;
	logic v1_reg; // Filter stage output valid
	logic v2_reg; // Gain stage output valid
	logic out_valid_reg;
	mcc_chan_s out_reg;
	mcc_smp_t vdel_reg [NPH]; // Voltage, current sample
	mcc_smp_t vold_reg [NPH]; // Voltage, previous sample
	// Datapath wires
	mcc_smp_t hpf_x [NCH];
	mcc_smp_t hpf_y [NCH];
	mcc_smp_t gp_y [NCUR];
	mcc_word_t rms_a [NPH];
	logic [NCH-1:0] int_en_vec;
	logic take;
	logic hpf_dis;
	logic multipoint_enable;
	logic derive;
	// Control bits
	assign hpf_dis = cfg0_reg[CFG0_HPFDIS];
	assign multipoint_enable = cfg0_reg[CFG0_MULTIPOINT_ENABLE];
	assign derive = accm_reg[ACCM_DERIVE];
	assign take = wb_cyc_i && wb_stb_i && !ack_reg;
	// Bus acknowledge, one cycle after the request, dropped next cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_reg <= 1'h0;
		end else begin
			ack_reg <= take;
		end
	end
	// Register writes; unmapped addresses are acknowledged and ignored
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg0_reg <= '0;
			cfg2_reg <= CFG2_RST;
			accm_reg <= '0;
			dico_reg <= DICO_RST;
			for (int i = 0; i < NCUR; i++) begin
				igain_reg[i] <= '0;
			end
			for (int i = 0; i < NTHR; i++) begin
				thr_lo_reg[i] <= '0;
				thr_hi_reg[i] <= '0;
			end
			for (int p = 0; p < NPH; p++) begin
				for (int k = 0; k < NREG; k++) begin
					mtg_reg[p][k] <= '0;
					phc_reg[p][k] <= '0;
				end
			end
		end else if (take && wb_we_i) begin
			case (wb_adr_i)
				CFG0_OFF: begin
					cfg0_reg <= mcc_merge(cfg0_reg, wb_dat_i, wb_sel_i) & CFG0_MASK;
				end
				CFG2_OFF: begin
					cfg2_reg <= mcc_merge(cfg2_reg, wb_dat_i, wb_sel_i) & CFG2_MASK;
				end
				ACCM_OFF: begin
					accm_reg <= mcc_merge(accm_reg, wb_dat_i, wb_sel_i) & ACCM_MASK;
				end
				DICO_OFF: begin
					dico_reg <= mcc_merge(dico_reg, wb_dat_i, wb_sel_i);
				end
				default: ;
			endcase
			for (int i = 0; i < NCUR; i++) begin
				if (wb_adr_i == IGAIN_OFF + AW'(REG_STRIDE * i)) begin
					igain_reg[i] <= mcc_merge(igain_reg[i], wb_dat_i, wb_sel_i);
				end
			end
			for (int i = 0; i < NTHR; i++) begin
				if (wb_adr_i == THR_LO_OFF + AW'(REG_STRIDE * i)) begin
					thr_lo_reg[i] <= mcc_merge(thr_lo_reg[i], wb_dat_i, wb_sel_i);
				end
				if (wb_adr_i == THR_HI_OFF + AW'(REG_STRIDE * i)) begin
					thr_hi_reg[i] <= mcc_merge(thr_hi_reg[i], wb_dat_i, wb_sel_i);
				end
			end
			for (int p = 0; p < NPH; p++) begin
				for (int k = 0; k < NREG; k++) begin
					if (wb_adr_i == MTGAIN_OFF + AW'(PH_STRIDE * p + REG_STRIDE * k)) begin
						mtg_reg[p][k] <= mcc_merge(mtg_reg[p][k], wb_dat_i, wb_sel_i);
					end
					if (wb_adr_i == PHCAL_OFF + AW'(PH_STRIDE * p + REG_STRIDE * k)) begin
						phc_reg[p][k] <= mcc_merge(phc_reg[p][k], wb_dat_i, wb_sel_i);
					end
				end
			end
		end
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		rd_word = '0;
		case (wb_adr_i)
			CFG0_OFF: rd_word = cfg0_reg;
			CFG2_OFF: rd_word = cfg2_reg;
			ACCM_OFF: rd_word = accm_reg;
			DICO_OFF: rd_word = dico_reg;
			REGION_OFF: begin
				// Live region of each phase, one nibble each
				for (int p = 0; p < NPH; p++) begin
					rd_word[REGION_W*p +: REGION_W] = REGION_W'(region_reg[p]);
				end
			end
			default: ;
		endcase
		for (int i = 0; i < NCUR; i++) begin
			if (wb_adr_i == IGAIN_OFF + AW'(REG_STRIDE * i)) begin
				rd_word = igain_reg[i];
			end
		end
		for (int i = 0; i < NTHR; i++) begin
			if (wb_adr_i == THR_LO_OFF + AW'(REG_STRIDE * i)) begin
				rd_word = thr_lo_reg[i];
			end
			if (wb_adr_i == THR_HI_OFF + AW'(REG_STRIDE * i)) begin
				rd_word = thr_hi_reg[i];
			end
		end
		for (int p = 0; p < NPH; p++) begin
			for (int k = 0; k < NREG; k++) begin
				if (wb_adr_i == MTGAIN_OFF + AW'(PH_STRIDE * p + REG_STRIDE * k)) begin
					rd_word = mtg_reg[p][k];
				end
				if (wb_adr_i == PHCAL_OFF + AW'(PH_STRIDE * p + REG_STRIDE * k)) begin
					rd_word = phc_reg[p][k];
				end
			end
		end
	end
	// Read data captured with the acknowledge
	always_ff @(posedge mclk) begin
		if (rst) begin
			dat_reg <= '0;
		end else if (take) begin
			dat_reg <= rd_word;
		end
	end
	// Channel inputs; phase B may be rebuilt from A and C
	assign hpf_x[0] = smp_in.ia;
	assign hpf_x[1] = derive ? -(smp_in.ia + smp_in.ic) : smp_in.ib;
	assign hpf_x[2] = smp_in.ic;
	assign hpf_x[3] = smp_in.ineu;
	assign hpf_x[4] = smp_in.va;
	assign hpf_x[5] = smp_in.vb;
	assign hpf_x[6] = smp_in.vc;
	assign rms_a[0] = rms_in.ia;
	assign rms_a[1] = rms_in.ib;
	assign rms_a[2] = rms_in.ic;
	// Voltages never integrate; neutral has its own enable
	assign int_en_vec = {3'h0, cfg0_reg[CFG0_NINT], {NPH{cfg0_reg[CFG0_PHINT]}}};
	// Filter and integrator on every channel
	for (genvar c = 0; c < NCH; c++) begin : g_hpf
		mcc_hpf_int u_hpf (
			.mclk(mclk),
			.rst(rst),
			.in_valid(smp_valid),
			.x(hpf_x[c]),
			.hpf_dis(hpf_dis),
			.corner(cfg2_reg[CFG2_CORNER_LSB +: CORNER_W]),
			.int_en(int_en_vec[c]),
			.dico(dico_reg),
			.y(hpf_y[c])
		);
	end

	// Gain and phase on current channels; neutral has no multipoint table
	for (genvar c = 0; c < NCUR; c++) begin : g_gp
		if (c < NPH) begin : g_ph
			mcc_gain_phase u_gp (
				.mclk(mclk),
				.rst(rst),
				.in_valid(v1_reg),
				.x(hpf_y[c]),
				.igain(igain_reg[c]),
				.mt_en(multipoint_enable),
				.mtgain(mtg_reg[c][region_reg[c]]),
				.phcal(phc_reg[c][region_reg[c]]),
				.y(gp_y[c])
			);
		end else begin : g_neu
			mcc_gain_phase u_gp (
				.mclk(mclk),
				.rst(rst),
				.in_valid(v1_reg),
				.x(hpf_y[c]),
				.igain(igain_reg[c]),
				.mt_en(1'h0),
				.mtgain('0),
				.phcal('0),
				.y(gp_y[c])
			);
		end
	end

	// Stage valids, one stage per clock after each sample
	always_ff @(posedge mclk) begin
		if (rst) begin
			v1_reg <= 1'h0;
			v2_reg <= 1'h0;
		end else begin
			v1_reg <= smp_valid;
			v2_reg <= v1_reg;
		end
	end

	// One-sample voltage delay sets the positive end of the phase range
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int p = 0; p < NPH; p++) begin
				vdel_reg[p] <= '0;
				vold_reg[p] <= '0;
			end
		end else if (v1_reg) begin
			for (int p = 0; p < NPH; p++) begin
				vdel_reg[p] <= hpf_y[VOFF + p];
				vold_reg[p] <= vdel_reg[p];
			end
		end
	end

	// Region hysteresis, after the gain stage so the next sample sees it
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int p = 0; p < NPH; p++) begin
				region_reg[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NPH; p++) begin
				if (!multipoint_enable) begin
					region_reg[p] <= '0;
				end else if (v2_reg) begin
					if (rms_a[p] > thr_hi_reg[region_reg[p]]) begin
						if (region_reg[p] <= REGION_UP_MAX) begin
							region_reg[p] <= region_reg[p] + 3'h1;
						end
					end else if (rms_a[p] < thr_lo_reg[region_reg[p]]) begin
						if (region_reg[p] >= REGION_DN_MIN) begin
							region_reg[p] <= region_reg[p] - 3'h1;
						end
					end
				end
			end
		end
	end

	// Output register
	always_ff @(posedge mclk) begin
		if (rst) begin
			out_valid_reg <= 1'h0;
			out_reg <= '0;
		end else begin
			out_valid_reg <= v2_reg;
			if (v2_reg) begin
				out_reg <= {gp_y[0], gp_y[1], gp_y[2], gp_y[3],
					vold_reg[0], vold_reg[1], vold_reg[2]};
			end
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign out_valid = out_valid_reg;
	assign out_smp = out_reg;
	// Checks on the datapath and the region logic
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	a_derive_b: assert property (
		smp_valid && derive && hpf_dis && !cfg0_reg[CFG0_PHINT]
		|=> hpf_y[1] == -($past(smp_in.ia) + $past(smp_in.ic)))
		else $error("phase B not derived");
	a_hpf_bypass: assert property (
		smp_valid && hpf_dis |=> hpf_y[VOFF] == $past(smp_in.va))
		else $error("high-pass bypass failed");
	a_reset_cfg: assert property (
		$past(rst) |-> cfg2_reg == CFG2_RST && !multipoint_enable)
		else $error("bad config after reset");
	a_phase_noint: assert property (
		smp_valid && hpf_dis && !cfg0_reg[CFG0_PHINT] |=> hpf_y[0] == $past(smp_in.ia))
		else $error("phase integrator active while off");
	a_neutral_indep: assert property (
		smp_valid && hpf_dis && !cfg0_reg[CFG0_NINT] |=> hpf_y[3] == $past(smp_in.ineu))
		else $error("neutral integrator not independent");
	a_volt_delay: assert property (
		out_valid_reg |-> out_reg.va == $past(hpf_y[VOFF], 3))
		else $error("voltage not delayed one sample");
	a_region_zero: assert property (
		!multipoint_enable |=> region_reg[0] == 3'h0)
		else $error("region not zero while disabled");
	a_region_up: assert property (
		v2_reg && multipoint_enable && $past(multipoint_enable) && rms_a[0] > thr_hi_reg[region_reg[0]]
		&& region_reg[0] <= REGION_UP_MAX |=> region_reg[0] == $past(region_reg[0]) + 3'h1)
		else $error("region did not step up");
	a_region_down: assert property (
		v2_reg && multipoint_enable && !(rms_a[0] > thr_hi_reg[region_reg[0]])
		&& rms_a[0] < thr_lo_reg[region_reg[0]] && region_reg[0] >= REGION_DN_MIN
		|=> region_reg[0] == $past(region_reg[0]) - 3'h1)
		else $error("region did not step down");
	a_region_hold: assert property (
		multipoint_enable && !v2_reg |=> $stable(region_reg[0]))
		else $error("region moved between samples");
	a_out_timing: assert property (
		smp_valid ##1 !smp_valid [*2] |=> out_valid_reg)
		else $error("output not three cycles after sample");
endmodule : mcc_top

// ---- testbench/mcc_smp_src.sv ----
// Behavioural decimator stage that hands samples and rms levels to the block
`timescale 1ns/1ps
module mcc_smp_src import mcc_pkg::*; (
	// Clock
	input wire logic mclk,
	// Sample stream towards the block
	output logic smp_valid,
	output mcc_chan_s smp_in,
	output mcc_rms_s rms_in
);
	// Idle values at time zero
	initial begin
		smp_valid = 1'b0;
		smp_in = '0;
		rms_in = '0;
	end

	// One pulse carries all seven channels together
	task automatic send(input mcc_chan_s c, input mcc_rms_s r);
		@(posedge mclk);
		smp_valid <= 1'b1;
		smp_in <= c;
		// Rms stays as a level, it is read later in the pipe
		rms_in <= r;
		@(posedge mclk);
		smp_valid <= 1'b0;
		// Data no longer qualified, so show a different pattern
		smp_in <= ~c;
	endtask : send
endmodule : mcc_smp_src

// ---- testbench/test_meter_channel_conditioning.sv ----
// Self-checking bench for the meter channel conditioning block
`timescale 1ns/1ps
module test_meter_channel_conditioning import mcc_pkg::*;;
	// Clock, reset and bus master signals
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [AW-1:0] adr = '0;
	logic [3:0] sel = 4'h0;
	mcc_word_t dat_i = '0;
	mcc_word_t dat_o;
	logic ack;
	// Stream signals
	logic smp_valid;
	mcc_chan_s smp_in;
	mcc_rms_s rms_in;
	logic out_valid;
	mcc_chan_s out_smp;
	// Score counters
	int n_mismatch = 0;
	int n_compared = 0;

	// Free-running 200 MHz clock
	always #2.5 mclk = ~mclk;

	mcc_top dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.smp_valid(smp_valid), .smp_in(smp_in), .rms_in(rms_in), .out_valid(out_valid),
		.out_smp(out_smp));

	mcc_smp_src src (.mclk(mclk), .smp_valid(smp_valid), .smp_in(smp_in), .rms_in(rms_in));

	// Compare and count
	task automatic check(input string what, input mcc_word_t seen, input mcc_word_t exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Verdict and end of run
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	// Synchronous reset held for twenty cycles
	task automatic do_reset();
		rst <= 1'b1;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
	endtask : do_reset

	// Classic single Wishbone cycle; request held until ack is sampled
	task automatic wb(input logic w, input logic [AW-1:0] a, input mcc_word_t d,
		output mcc_word_t q);
		int t;
		t = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat_i <= d;
		do begin
			@(posedge mclk);
			t++;
		end while (ack !== 1'b1 && t < 50);
		// A silent slave counts against the run
		if (t >= 50) n_mismatch++;
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	// Register write
	task automatic wr(input logic [AW-1:0] a, input mcc_word_t d);
		mcc_word_t q;
		wb(1'b1, a, d, q);
	endtask : wr

	// Register read against an expected value
	task automatic rd(input string what, input logic [AW-1:0] a, input mcc_word_t exp);
		mcc_word_t q;
		wb(1'b0, a, '0, q);
		check(what, q, exp);
	endtask : rd

	// One sample in, the conditioned sample out
	task automatic smp(input mcc_chan_s c, input mcc_rms_s r, output mcc_chan_s o);
		int t;
		src.send(c, r);
		t = 0;
		do begin
			@(posedge mclk);
			t++;
		end while (out_valid !== 1'b1 && t < 20);
		if (t >= 20) n_mismatch++;
		o = out_smp;
	endtask : smp

	// Build a sample; all three voltages share one value
	function automatic mcc_chan_s mk(input mcc_smp_t a, b, c, n, v);
		mk = '{ia: a, ib: b, ic: c, ineu: n, va: v, vb: v, vc: v};
	endfunction : mk

	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end

	// Test sequence
	initial begin
		mcc_chan_s o;
		mcc_rms_s r;
		mcc_smp_t x;
		do_reset();
		// Reset values, field masks and an unmapped place
		rd("cfg0", CFG0_OFF, 32'h0);
		rd("cfg2", CFG2_OFF, 32'h6);
		rd("accm", ACCM_OFF, 32'h0);
		rd("dico", DICO_OFF, 32'hffffe000);
		rd("region", REGION_OFF, 32'h0);
		rd("unmapped", 12'h3f0, 32'h0);
		wr(CFG2_OFF, 32'hffffffff);
		rd("cfg2 mask", CFG2_OFF, 32'h7);
		$display("test registers done");
		// Every corner code: dc step loses exactly 16 on the first sample
		for (int c = 0; c < 8; c++) begin
			do_reset();
			// Code six is left at its reset value on purpose
			if (c != 6) wr(CFG2_OFF, 32'(c));
			x = 32'sd1 <<< (8 + c);
			smp(mk(x, x, x, x, x), '0, o);
			smp(mk(x, x, x, x, x), '0, o);
			check("hpf va", o.va, x - 32'sd16);
			check("hpf ia", o.ia, x - 32'sd16);
		end
		$display("test highpass done");
		// Gain, derived phase B and the one-sample voltage delay
		do_reset();
		wr(CFG0_OFF, 32'h1);
		wr(ACCM_OFF, 32'h1);
		wr(IGAIN_OFF, 32'h08000000);
		wr(IGAIN_OFF + 12'h4, 32'hf0000000);
		smp(mk(10, 999, 7, 0, 100), '0, o);
		check("va first", o.va, 32'h0);
		smp(mk(0, 0, 0, 0, 0), '0, o);
		check("gain ia", o.ia, 32'd20);
		check("derived ib", o.ib, 32'd17);
		check("plain ic", o.ic, 32'd7);
		check("delay va", o.va, 32'd100);
		check("delay vc", o.vc, 32'h64);
		$display("test gain done");
		// Phase then neutral integrator; the other path stays plain
		for (int m = 0; m < 2; m++) begin
			do_reset();
			wr(CFG0_OFF, m ? 32'h5 : 32'h3);
			smp(mk(1600, 1600, 1600, 1600, 0), '0, o);
			smp(mk(1600, 1600, 1600, 1600, 0), '0, o);
			x = m ? o.ineu : o.ia;
			// First sample's accumulator over 16, seen through the one-sample current delay
			check("int path", x, 32'h64);
			check("plain path", m ? o.ia : o.ineu, 32'd1600);
		end
		$display("test integrator done");
		// Multipoint region climb, limit, extra gain, step down and disable
		do_reset();
		wr(CFG0_OFF, 32'h9);
		for (int k = 0; k < NTHR; k++) wr(THR_HI_OFF + 12'(4 * k), 32'd100);
		r = '0;
		r.ia = 32'd200;
		for (int k = 1; k <= 6; k++) begin
			smp(mk(0, 0, 0, 0, 0), r, o);
			rd("region up", REGION_OFF, (k > 4) ? 32'h4 : 32'(k));
		end
		wr(MTGAIN_OFF + 12'h10, 32'h08000000);
		wr(MTGAIN_OFF, 32'h08000000);
		// Region four coefficient of one half: y = x[n-1] + (x[n] - y[n-1]) / 2
		wr(PHCAL_OFF + 12'h10, 32'h04000000);
		smp(mk(10, 0, 0, 0, 0), r, o);
		check("phase first", o.ia, 32'h0a);
		smp(mk(0, 0, 0, 0, 0), r, o);
		check("mt gain", o.ia, 32'h0f);
		// High threshold above the rms level, so only the low threshold decides
		wr(THR_HI_OFF + 12'h10, 32'h190);
		wr(THR_LO_OFF + 12'h10, 32'd300);
		smp(mk(0, 0, 0, 0, 0), r, o);
		rd("region down", REGION_OFF, 32'h3);
		wr(CFG0_OFF, 32'h1);
		rd("region off", REGION_OFF, 32'h0);
		smp(mk(10, 0, 0, 0, 0), r, o);
		smp(mk(0, 0, 0, 0, 0), r, o);
		check("no mt gain", o.ia, 32'd10);
		$display("test multipoint done");
		report_and_stop();
	end
endmodule : test_meter_channel_conditioning
